// file: bench/tmo_far.sv
// Far-side model: line sync source and position feedback pulses
`timescale 1ns/10ps
module tmo_far (
	input  wire logic  aclk,
	output logic       sync_pin,
	output logic [3:0] count_pin
);
	initial begin
		sync_pin = 1'b0;
		count_pin = 4'h0;
	end
	// Level held 30 cycles so the pin filter surely passes it
	task automatic sync_to(input logic lvl);
		@(posedge aclk);
		sync_pin <= lvl;
		repeat (30) @(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic pulses(input int pin, input int k);
		repeat (k) begin
			@(posedge aclk);
			count_pin[pin] <= 1'b1;
			repeat (10) @(posedge aclk);
			count_pin[pin] <= 1'b0;
			repeat (9) @(posedge aclk);
		end
		@(negedge aclk);
	endtask
endmodule // tmo_far

// file: bench/tmo_timer_chk.sv
// Checker of bus handshakes and idle output levels
`timescale 1ns/10ps
module tmo_timer_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        wave_out,
	input wire logic        busy
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer withdrawn");
	chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer withdrawn");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while read answer pending");
	chk_r_answer: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read answer without request");
	chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write answer late");
	chk_aw_refused: assert property (s_axi_awvalid && s_axi_awready
		&& !(s_axi_wvalid && s_axi_wready) |=> !s_axi_awready) else $error("second address taken");
	chk_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
	chk_idle_low: assert property (disable iff (1'b0) !aresetn
		|=> !s_axi_bvalid && !s_axi_rvalid && !wave_out && !busy) else $error("not idle after reset");
	cov_busy: cover property ($rose(busy));
	cov_wave: cover property ($rose(wave_out));
	cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // tmo_timer_chk

bind tmo_timer tmo_timer_chk i_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wave_out(wave_out), .busy(busy));

// file: bench/tmo_timer_tb.sv
// Self-checking bench of the waveform timer
`timescale 1ns/10ps
`include "tmo_regs.vh"
module tmo_timer_tb;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF, strb = 4'hF;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire         awready, wready, bvalid, arready, rvalid, sync_pin, wave_out, busy;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [3:0]  count_pin;
	int          error_cnt = 0, n_compared = 0, cyc = 0, n;

	tmo_timer #(.TRIAC_WAIT_CYC(20'd200)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sync_pin(sync_pin), .count_pin(count_pin), .wave_out(wave_out), .busy(busy));
	tmo_far i_far (.aclk(aclk), .sync_pin(sync_pin), .count_pin(count_pin));

	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic near(input string nm, input int v, input int e, input int tol);
		chk(nm, (v >= e - tol && v <= e + tol) ? e : v, e);
	endtask
	task automatic wt(input int c);
		repeat (c) @(negedge aclk);
	endtask
	// Ready is looked at mid-cycle, valid drops at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, da, dw;
		da = 1'b0;
		dw = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(da && dw)) begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			da = da | ta;
			dw = dw | tw;
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		chk("bresp", bresp, er);
		@(posedge aclk);
		bready <= 1'b0;
		@(negedge aclk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		chk("rdata", rdata, ed);
		chk("rresp", rresp, er);
		@(posedge aclk);
		rready <= 1'b0;
		@(negedge aclk);
	endtask
	task automatic ctl(input logic [31:0] v);
		wr(`TMO_ADDR_CTRL, v, `TMO_RESP_OKAY);
	endtask
	task automatic val(input logic [31:0] v);
		wr(`TMO_ADDR_VALUE, v, `TMO_RESP_OKAY);
	endtask
	// Cycles the output spends at one level, from now if already there, else from the next time it gets there
	task automatic run_len(input logic lvl, output int k);
		k = 0;
		while (wave_out !== lvl) @(negedge aclk);
		while (wave_out === lvl) begin
			k++;
			@(negedge aclk);
		end
	endtask

	// ----------------------------------------------------------------
	// Tests; a tick is two cycles at clock select 0, four in pulse count mode
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(`TMO_ADDR_CTRL, 32'h0, `TMO_RESP_OKAY);
		chk("idle", wave_out, 1'b0);
		rd_chk(8'h20, 32'h0, `TMO_RESP_SLVERR);
		wr(8'h20, 32'h1, `TMO_RESP_SLVERR);
		ctl(32'h1);
		val(32'h4);
		wt(1);
		chk("freq_start", wave_out, 1'b1);
		run_len(1'b0, n);
		near("freq_low", n, 8, 0);
		val(32'h6);
		run_len(1'b1, n);
		run_len(1'b1, n);
		near("freq_reload", n, 12, 0);
		while (wave_out !== 1'b1) @(negedge aclk);
		val(32'h0);
		wt(2);
		chk("freq_stop", wave_out, 1'b0);
		ctl(32'h81);
		wt(3);
		chk("freq_inv_idle", wave_out, 1'b1);
		ctl(32'h3);
		fork val(32'd10); run_len(1'b1, n); join
		near("oneshot", n, 20, 2);
		fork begin val(32'd40); wt(20); val(32'd40); end run_len(1'b1, n); join
		near("retrigger", n, 103, 4);
		ctl(32'h83);
		fork val(32'd10); run_len(1'b0, n); join
		near("oneshot_low", n, 20, 2);
		ctl(32'h4);
		val(32'd2);
		chk("pc_busy", busy, 1'b1);
		// First pulse may lose part of a tick; the second one is whole
		run_len(1'b1, n);
		chk("pc_busy_mid", busy, 1'b1);
		run_len(1'b1, n);
		near("pc_high", n, 512, 1);
		wt(600);
		chk("pc_done", busy, 1'b0);
		chk("pc_no_extra", wave_out, 1'b0);
		ctl(32'h84);
		wt(2);
		chk("pc_inv_idle", wave_out, 1'b1);
		ctl(32'h5);
		val(32'd64);
		run_len(1'b1, n);
		run_len(1'b1, n);
		near("pwm_on", n, 128, 0);
		run_len(1'b0, n);
		near("pwm_off", n, 384, 0);
		ctl(32'h85);
		val(32'd64);
		run_len(1'b0, n);
		run_len(1'b0, n);
		near("pwm_inv_on", n, 128, 0);
		ctl(32'h6);
		fork val(32'd64); run_len(1'b1, n); join
		near("lpwm_on", n, 128, 1);
		// A short period would have raised the output again by now
		wt(400);
		chk("lpwm_period", wave_out, 1'b0);
		ctl(32'h7);
		val(32'd10);
		chk("triac_wait", busy, 1'b1);
		fork i_far.sync_to(1'b1); run_len(1'b1, n); join
		near("gate", n, 256, 1);
		chk("triac_free", busy, 1'b0);
		i_far.sync_to(1'b0);
		fork i_far.sync_to(1'b1); run_len(1'b1, n); join
		near("gate_again", n, 256, 1);
		i_far.sync_to(1'b0);
		for (int e = 0; e < 3; e++) begin
			ctl(32'h7 | (e << 8));
			val(32'd10);
			i_far.sync_to(1'b1);
			chk("edge_rise", busy, e == 1);
			i_far.sync_to(1'b0);
			chk("edge_fall", busy, 1'b0);
		end
		ctl(32'h87);
		val(32'd10);
		fork i_far.sync_to(1'b1); run_len(1'b0, n); join
		near("gate_inv", n, 256, 1);
		ctl(32'h7);
		val(32'd10);
		wt(150);
		chk("stall_on", busy, 1'b1);
		wt(100);
		chk("stall_end", busy, 1'b0);
		ctl(32'h808);
		val(32'd3);
		wt(2);
		chk("trig_on", wave_out, 1'b1);
		i_far.pulses(1, 3);
		i_far.pulses(2, 2);
		chk("trig_mid", wave_out, 1'b1);
		i_far.pulses(2, 1);
		chk("trig_off", wave_out, 1'b0);
		ctl(32'h888);
		val(32'd1);
		wt(2);
		chk("trig_inv_on", wave_out, 1'b0);
		i_far.pulses(2, 1);
		chk("trig_inv_off", wave_out, 1'b1);
		// Byte lane 1 cleared alone, lane 0 must keep its value
		wr(`TMO_ADDR_IR_MOD, 32'h1102, `TMO_RESP_OKAY);
		strb = 4'h2;
		wr(`TMO_ADDR_IR_MOD, 32'h0, `TMO_RESP_OKAY);
		strb = 4'hF;
		rd_chk(`TMO_ADDR_IR_MOD, 32'h2, `TMO_RESP_OKAY);
		// Carrier half period 2 ticks; burst 8, gap 4, burst 2 ticks
		wr(`TMO_ADDR_IR_LEN, 32'd3, `TMO_RESP_OKAY);
		wr(8'h40, 32'd8, `TMO_RESP_OKAY);
		wr(8'h44, 32'd4, `TMO_RESP_OKAY);
		wr(8'h48, 32'd2, `TMO_RESP_OKAY);
		ctl(32'h2);
		fork val(32'h1); run_len(1'b1, n); join
		near("ir_burst_start", n, 4, 1);
		run_len(1'b1, n);
		near("ir_carrier", n, 4, 0);
		run_len(1'b0, n);
		near("ir_gap", n, 12, 0);
		run_len(1'b1, n);
		near("ir_burst_next", n, 4, 0);
		wt(8);
		rd_chk(`TMO_ADDR_STATUS, 32'h0, `TMO_RESP_OKAY);
		print_verdict();
	end
endmodule // tmo_timer_tb

// file: rtl/tmo_presc.v
// Free-running prescaler: timer tick and fixed triac gate clock
`timescale 1ns/10ps
`include "tmo_regs.vh"
module tmo_presc (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire [2:0] cs,
	output reg        tick,
	output reg        triac_en
);
	reg  [7:0] cnt;
	wire [7:0] mask;

	// Tick every TICK_CYC * 2^cs clocks; one counter keeps all rates aligned
	assign mask = ((8'h01 << cs) << (`TMO_TICK_CYC - 1)) - 8'h01;

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt      <= 8'h00;
			tick     <= 1'b0;
			triac_en <= 1'b0;
		end else begin
			cnt      <= cnt + 8'h01;
			tick     <= ((cnt & mask) == mask);
			triac_en <= (cnt == (`TMO_TRIAC_CLK_CYC - 1));
		end
	end
endmodule // tmo_presc

// file: rtl/tmo_regs.vh
// Register map, field positions and timing constants of the waveform timer
// ----------------------------------------------------------------------------
// Functional notes
// - Frequency reload waits for the period end
// - Idle frequency starts at once, zero stops
// - Disabled output rests low, high if inverted
// - First infrared entry sets burst length
// - Following entries alternate gap and burst lengths
// - Oneshot single pulse, polarity selectable
// - Reloading active oneshot extends it immediately
// - Oneshot length within one timer tick
// - Pulse count emits N square pulses
// - Busy holds until every pulse is out
// - Pulse count idles low, inversion reverses
// - Short pulsewidth on-time in 1/256 steps
// - Long pulsewidth on-time in 1/65536 steps
// - Pulsewidth asserted level is configurable
// - Pulsewidth reload at period end, exceptions
// - Triac sync edge: rising, falling, both
// - Triac delay latched at sync edge, repeats
// - Gate pulse timed by fixed internal clock
// - Triac load stalls requester up to 10 ms
// - Sync edge and gate polarity set independently
// - Triggered count asserts until N edges
// - Triggered count asserted high unless inverted
// - Frequency output is 50 percent square wave
// - Short period 256 ticks, no count at select 0; here select 0 ticks every 2 cycles, pulse count every 4
// - Long period 65536 ticks, doubling per select
// - Programmed counts are 16-bit unsigned
// ----------------------------------------------------------------------------
`ifndef TMO_REGS_VH
`define TMO_REGS_VH

`define TMO_ADDR_CTRL     8'h00
`define TMO_ADDR_VALUE    8'h04
`define TMO_ADDR_IR_MOD   8'h08
`define TMO_ADDR_IR_LEN   8'h0C
`define TMO_ADDR_STATUS   8'h10
`define TMO_ADDR_IR_BASE  2'b01

`define TMO_F_MODE        3:0
`define TMO_F_CS          6:4
`define TMO_F_INV         7
`define TMO_F_EDGE        9:8
`define TMO_F_PIN         11:10

`define TMO_M_OFF         4'h0
`define TMO_M_FREQ        4'h1
`define TMO_M_IR          4'h2
`define TMO_M_ONESHOT     4'h3
`define TMO_M_PCOUNT      4'h4
`define TMO_M_PWM_SHORT   4'h5
`define TMO_M_PWM_LONG    4'h6
`define TMO_M_TRIAC       4'h7
`define TMO_M_TRIG        4'h8

`define TMO_E_RISE        2'h0
`define TMO_E_FALL        2'h1

`define TMO_RESP_OKAY     2'h0
`define TMO_RESP_SLVERR   2'h2

`define TMO_CLK_MHZ       25
`define TMO_TICK_NS_MHZ   2000
`define TMO_TICK_CYC      (`TMO_TICK_NS_MHZ / 1000)
`define TMO_TRIAC_CLK_NS  25600
`define TMO_TRIAC_REF_MHZ 10
`define TMO_TRIAC_CLK_CYC (`TMO_TRIAC_CLK_NS * `TMO_TRIAC_REF_MHZ / 1000)
`define TMO_TRIAC_WAIT_US 10000
`define TMO_TRIAC_WAIT_CYC (`TMO_TRIAC_WAIT_US * `TMO_CLK_MHZ)
`define TMO_PCOUNT_HALF   16'h007F
`define TMO_SHORT_WRAP    8'hFF
`define TMO_LONG_WRAP     16'hFFFF

`endif

// file: rtl/tmo_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module tmo_sync #(
	parameter WIDTH = 5
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [WIDTH-1:0] pin,
	output wire [WIDTH-1:0] level
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg s1;
			reg s2;
			reg s3;
			reg lvl;
			always @(posedge aclk) begin
				if (!aresetn) begin
					s1  <= 1'b0;
					s2  <= 1'b0;
					s3  <= 1'b0;
					lvl <= 1'b0;
				end else begin
					s1 <= pin[i];
					s2 <= s1;
					s3 <= s2;
					// Only a level that two stages agree on is taken
					if (s2 == s3) begin
						lvl <= s3;
					end
				end
			end
			assign level[i] = lvl;
		end
	endgenerate
endmodule // tmo_sync

// file: rtl/tmo_timer.v
// Timer/counter output waveform generator with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "tmo_regs.vh"
module tmo_timer #(
	parameter        IR_DEPTH       = 16,
	parameter [19:0] TRIAC_WAIT_CYC = `TMO_TRIAC_WAIT_CYC
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        sync_pin,
	input  wire [3:0]  count_pin,
	output reg         wave_out,
	output wire        busy
);
	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	reg  [7:0]  aw_addr;
	reg         aw_v;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg         w_v;
	reg  [11:0] ctrl;
	reg  [15:0] val_reg;
	reg  [15:0] ir_mod;
	reg  [4:0]  ir_len;
	reg  [15:0] ir_tab [0:IR_DEPTH-1];
	wire        wr_fire;
	wire        rd_fire;
	wire [31:0] wr_val;
	wire [31:0] old_val;
	wire        ir_hit_w;
	wire        ir_hit_r;
	wire        ctrl_wr;
	wire        ld;
	reg  [31:0] rd_mux;
	reg         rd_ok;
	reg         wr_ok;

	assign s_axi_awready = !aw_v;
	assign s_axi_wready  = !w_v;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_v && w_v && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
	assign ir_hit_w = (aw_addr[7:6] == `TMO_ADDR_IR_BASE) && (aw_addr[5:2] < IR_DEPTH);
	assign ir_hit_r = (s_axi_araddr[7:6] == `TMO_ADDR_IR_BASE)
		&& (s_axi_araddr[5:2] < IR_DEPTH);

	// Current contents of the word being written, for byte-lane merging
	assign old_val =
		(aw_addr == `TMO_ADDR_CTRL)   ? {20'h00000, ctrl} :
		(aw_addr == `TMO_ADDR_VALUE)  ? {16'h0000, val_reg} :
		(aw_addr == `TMO_ADDR_IR_MOD) ? {16'h0000, ir_mod} :
		(aw_addr == `TMO_ADDR_IR_LEN) ? {27'h0000000, ir_len} :
		ir_hit_w ? {16'h0000, ir_tab[aw_addr[5:2]]} : 32'h00000000;

	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_lane
			assign wr_val[8*b+7:8*b] = w_strb[b] ? w_data[8*b+7:8*b] : old_val[8*b+7:8*b];
		end
	endgenerate

	assign ctrl_wr = wr_fire && (aw_addr == `TMO_ADDR_CTRL);
	assign ld      = wr_fire && (aw_addr == `TMO_ADDR_VALUE);

	always @* begin
		wr_ok = (aw_addr == `TMO_ADDR_CTRL) || (aw_addr == `TMO_ADDR_VALUE)
			|| (aw_addr == `TMO_ADDR_IR_MOD) || (aw_addr == `TMO_ADDR_IR_LEN)
			|| (aw_addr == `TMO_ADDR_STATUS) || ir_hit_w;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr      <= 8'h00;
			aw_v         <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			w_v          <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TMO_RESP_OKAY;
			ctrl         <= 12'h000;
			val_reg      <= 16'h0000;
			ir_mod       <= 16'h0000;
			ir_len       <= 5'h00;
		end else begin
			if (s_axi_awvalid && !aw_v) begin
				aw_addr <= s_axi_awaddr;
				aw_v    <= 1'b1;
			end
			if (s_axi_wvalid && !w_v) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_v    <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_fire) begin
				aw_v         <= 1'b0;
				w_v          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `TMO_RESP_OKAY : `TMO_RESP_SLVERR;
				case (aw_addr)
					`TMO_ADDR_CTRL:   ctrl    <= wr_val[11:0];
					`TMO_ADDR_VALUE:  val_reg <= wr_val[15:0];
					`TMO_ADDR_IR_MOD: ir_mod  <= wr_val[15:0];
					`TMO_ADDR_IR_LEN: ir_len  <= wr_val[4:0];
					default: ;
				endcase
			end
		end
	end

	// Table has no reset; software fills it before starting a pattern
	always @(posedge aclk) begin
		if (wr_fire && ir_hit_w) begin
			ir_tab[aw_addr[5:2]] <= wr_val[15:0];
		end
	end

	// ------------------------------------------------------------------
	// Timing sources and pin edges
	// ------------------------------------------------------------------
	wire [3:0] mode;
	wire [2:0] cs;
	wire [2:0] cs_eff;
	wire       inv;
	wire [1:0] edge_sel;
	wire       tick;
	wire       triac_en;
	wire [4:0] pin_lvl;
	reg  [4:0] pin_d;
	wire       sync_edge;
	wire       cnt_edge;
	wire       cnt_lvl;
	wire       cnt_old;

	assign mode     = ctrl[`TMO_F_MODE];
	assign cs       = ctrl[`TMO_F_CS];
	assign inv      = ctrl[`TMO_F_INV];
	assign edge_sel = ctrl[`TMO_F_EDGE];
	assign cs_eff = ((mode == `TMO_M_PCOUNT) && (cs == 3'h0)) ? 3'h1 : cs;

	tmo_presc u_presc (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.cs       (cs_eff),
		.tick     (tick),
		.triac_en (triac_en)
	);

	tmo_sync #(
		.WIDTH (5)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     ({count_pin, sync_pin}),
		.level   (pin_lvl)
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_d <= 5'h00;
		end else begin
			pin_d <= pin_lvl;
		end
	end

	assign cnt_lvl = pin_lvl[ctrl[`TMO_F_PIN] + 3'h1];
	assign cnt_old = pin_d[ctrl[`TMO_F_PIN] + 3'h1];

	assign sync_edge = (edge_sel == `TMO_E_RISE) ? (pin_lvl[0] && !pin_d[0]) :
		(edge_sel == `TMO_E_FALL) ? (!pin_lvl[0] && pin_d[0]) : (pin_lvl[0] != pin_d[0]);
	assign cnt_edge = (edge_sel == `TMO_E_RISE) ? (cnt_lvl && !cnt_old) :
		(edge_sel == `TMO_E_FALL) ? (!cnt_lvl && cnt_old) : (cnt_lvl != cnt_old);

	// ------------------------------------------------------------------
	// Waveform engine
	// ------------------------------------------------------------------
	reg  [15:0] cur;
	reg  [15:0] pend;
	reg         pend_v;
	reg  [15:0] cnt;
	reg  [15:0] rem;
	reg  [15:0] bcnt;
	reg  [4:0]  idx;
	reg         act;
	reg         en;
	reg         twait;
	reg  [19:0] tcnt;
	reg         dly_run;
	reg         gate_req;
	reg         gate;
	wire [15:0] ld_v;
	wire [15:0] seg_len;
	wire        pwm_wrap;
	wire        pwm_on;
	wire [15:0] tri_next;
	reg         level;

	assign ld_v     = wr_val[15:0];
	assign seg_len  = ir_tab[idx[3:0]];
	assign pwm_wrap = (mode == `TMO_M_PWM_SHORT) ? (cnt[7:0] == `TMO_SHORT_WRAP)
		: (cnt == `TMO_LONG_WRAP);
	assign pwm_on   = (mode == `TMO_M_PWM_SHORT) ? (cnt[7:0] < cur[7:0]) : (cnt < cur);
	assign tri_next = pend_v ? pend : cur;
	assign busy     = ((mode == `TMO_M_PCOUNT) && en) || ((mode == `TMO_M_TRIAC) && twait);

	always @(posedge aclk) begin
		if (!aresetn || ctrl_wr) begin
			cur      <= 16'h0000;
			pend     <= 16'h0000;
			pend_v   <= 1'b0;
			cnt      <= 16'h0000;
			rem      <= 16'h0000;
			bcnt     <= 16'h0000;
			idx      <= 5'h00;
			act      <= 1'b0;
			en       <= 1'b0;
			twait    <= 1'b0;
			tcnt     <= 20'h00000;
			dly_run  <= 1'b0;
			gate_req <= 1'b0;
			gate     <= 1'b0;
		end else begin
			case (mode)
			`TMO_M_FREQ, `TMO_M_PWM_SHORT, `TMO_M_PWM_LONG: begin
				if (ld && (((mode == `TMO_M_PWM_SHORT) ? ld_v[7:0] : ld_v) == 16'h0000)) begin
					en     <= 1'b0;
					act    <= 1'b0;
					pend_v <= 1'b0;
				end else if (ld && !en) begin
					cur <= ld_v;
					cnt <= 16'h0000;
					act <= 1'b1;
					en  <= 1'b1;
				end else if (ld) begin
					pend   <= ld_v;
					pend_v <= 1'b1;
				end else if (tick && en && (mode == `TMO_M_FREQ)) begin
					if (cnt == cur - 16'h0001) begin
						cnt <= 16'h0000;
						act <= !act;
						if (!act && pend_v) begin
							cur    <= pend;
							pend_v <= 1'b0;
						end
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end else if (tick && en) begin
					if (pwm_wrap) begin
						cnt <= 16'h0000;
						if (pend_v) begin
							cur    <= pend;
							pend_v <= 1'b0;
						end
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
			end
			`TMO_M_IR: begin
				if (ld && (ir_len != 5'h00)) begin
					cur  <= ir_mod;
					cnt  <= 16'h0000;
					act  <= 1'b1;
					en   <= 1'b1;
					idx  <= 5'h00;
					bcnt <= 16'h0000;
				end else if (tick && en) begin
					if (cnt >= cur - 16'h0001) begin
						cnt <= 16'h0000;
						act <= (cur == 16'h0000) ? act : !act;
					end else begin
						cnt <= cnt + 16'h0001;
					end
					if ((seg_len == 16'h0000) || (bcnt == seg_len - 16'h0001)) begin
						bcnt <= 16'h0000;
						if (idx == ir_len - 5'h01) begin
							en <= 1'b0;
						end else begin
							idx <= idx + 5'h01;
						end
					end else begin
						bcnt <= bcnt + 16'h0001;
					end
				end
			end
			`TMO_M_ONESHOT: begin
				if (ld) begin
					cur <= ld_v;
					cnt <= 16'h0000;
					en  <= (ld_v != 16'h0000);
				end else if (tick && en) begin
					if (cnt == cur - 16'h0001) begin
						en <= 1'b0;
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
			end
			`TMO_M_PCOUNT: begin
				if (ld) begin
					rem <= ld_v;
					cnt <= 16'h0000;
					act <= (ld_v != 16'h0000);
					en  <= (ld_v != 16'h0000);
				end else if (tick && en) begin
					if (cnt == `TMO_PCOUNT_HALF) begin
						cnt <= 16'h0000;
						act <= !act;
						if (act) begin
							rem <= rem - 16'h0001;
							if (rem == 16'h0001) begin
								en  <= 1'b0;
								act <= 1'b0;
							end
						end
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
			end
			`TMO_M_TRIAC: begin
				if (ld) begin
					pend   <= ld_v;
					pend_v <= 1'b1;
					twait  <= 1'b1;
					tcnt   <= 20'h00000;
				end else if (twait) begin
					tcnt <= tcnt + 20'h00001;
					if (tcnt == TRIAC_WAIT_CYC - 20'h00001) begin
						twait <= 1'b0;
					end
				end
				if (sync_edge && !ld) begin
					cur     <= tri_next;
					pend_v  <= 1'b0;
					twait   <= 1'b0;
					en      <= (tri_next != 16'h0000);
					dly_run <= (tri_next != 16'h0000);
					cnt     <= 16'h0000;
				end else if (tick && dly_run) begin
					if (cnt == cur - 16'h0001) begin
						dly_run  <= 1'b0;
						gate_req <= 1'b1;
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
				if (triac_en) begin
					gate <= gate_req;
					if (gate_req && !(tick && dly_run && (cnt == cur - 16'h0001))) begin
						gate_req <= 1'b0;
					end
				end
			end
			`TMO_M_TRIG: begin
				if (ld) begin
					rem <= ld_v;
					en  <= (ld_v != 16'h0000);
				end else if (cnt_edge && en) begin
					rem <= rem - 16'h0001;
					if (rem == 16'h0001) begin
						en <= 1'b0;
					end
				end
			end
			default: begin
				en <= 1'b0;
			end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Output stage
	// ------------------------------------------------------------------
	always @* begin
		case (mode)
			`TMO_M_FREQ:      level = en && act;
			`TMO_M_IR:        level = en && !idx[0] && act;
			`TMO_M_ONESHOT:   level = en;
			`TMO_M_PCOUNT:    level = en && act;
			`TMO_M_PWM_SHORT: level = en && pwm_on;
			`TMO_M_PWM_LONG:  level = en && pwm_on;
			`TMO_M_TRIAC:     level = gate;
			`TMO_M_TRIG:      level = en;
			default:          level = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			wave_out <= 1'b0;
		end else begin
			wave_out <= level ^ inv;
		end
	end

	// ------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------
	always @* begin
		rd_ok  = 1'b1;
		rd_mux = 32'h00000000;
		case (s_axi_araddr)
			`TMO_ADDR_CTRL:   rd_mux = {20'h00000, ctrl};
			`TMO_ADDR_VALUE:  rd_mux = {16'h0000, cur};
			`TMO_ADDR_IR_MOD: rd_mux = {16'h0000, ir_mod};
			`TMO_ADDR_IR_LEN: rd_mux = {27'h0000000, ir_len};
			`TMO_ADDR_STATUS: rd_mux = {27'h0000000, pend_v, twait, wave_out, busy, en};
			default: begin
				if (ir_hit_r) begin
					rd_mux = {16'h0000, ir_tab[s_axi_araddr[5:2]]};
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `TMO_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_ok ? `TMO_RESP_OKAY : `TMO_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // tmo_timer
